// >>> hw/usbsie_ctrl.sv
// usbsie_ctrl: endpoint and bus-line control/status registers of the low-speed engine
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ns

// Function
// - access-flag register holds one read-only bit per endpoint, set on host access
// - direction bits for endpoints 1..3: 1 means IN, 0 means OUT, IN by default
// - direction bit 0 low forces data toggles of endpoints 1..3 to DATA0
// - enable bits 1..3 enable endpoints 1..3; endpoint 0 always enabled
// - end-of-packet sets bus-state bit 0, sticky until firmware clears it
// - J state sets bit 1, K state sets bit 2, both sticky
// - SE0 noise sets bit 3, SE1 noise sets bit 4, both sticky
// - deferred-address bit set: load address only after a successful IN read
// - engine clears the deferred-address bit after updating the address
// - deferred-address bit clear: written address applies at once
// - FIFO0 access error sets status bit 1, sticky until firmware clears it
// - status bit 7 set: endpoint 0 interrupts only on real data, not NAK
// - USB bus reset clears the FIFO command/status register
// - endpoint access sets its request flag and raises the interrupt
module usbsie_ctrl #(
    parameter int HADDR_W = 32,
    parameter int EP_NUM = 4
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // engine events, one-cycle pulses on hclk
    input wire logic ev_eop,
    input wire logic ev_j_state,
    input wire logic ev_k_state,
    input wire logic ev_se0_noise,
    input wire logic ev_se1_noise,
    input wire logic host_access,
    input wire logic [1:0] host_ep,
    input wire logic host_nak,
    input wire logic in_read_ok,
    input wire logic fifo0_err_ev,
    input wire logic usb_bus_reset,
    // control towards the engine
    output logic activity_strobe,
    output logic usb_irq,
    output logic [6:0] dev_addr,
    output logic remote_wakeup,
    output logic [2:0] ep_dir_in,
    output logic [3:0] ep_halt,
    output logic [2:0] ep_enabled,
    output logic toggle_clear,
    output logic [7:0] fifo_cmd_status
);
    initial begin
        if (EP_NUM != 4) begin
            $error("usbsie_ctrl: only four endpoints are supported");
        end
        if (HADDR_W < 10) begin
            $error("usbsie_ctrl: HADDR_W must be at least 10");
        end
        // the line flags are packed into the low five bits of their register
        if (usbsie_pkg::LF_SE1 > 4) begin
            $error("usbsie_ctrl: line flag positions exceed five bits");
        end
        // the strobes compare a one-byte index
        if (usbsie_pkg::HADDR_IDX_HI - usbsie_pkg::HADDR_IDX_LO != 7) begin
            $error("usbsie_ctrl: register index field must be eight bits");
        end
    end

    typedef struct packed {
        logic [4:0] line_flags;
        logic [3:1] dir_in;
        logic data0;
        logic [3:0] halt;
        logic [3:0] access;
        logic adr_set;
        logic fifo_zero_error;
        logic nak_filt;
        logic [3:0] enable;
        logic [7:0] addr_reg;
        logic [6:0] dev_addr;
        logic [3:0] req;
        logic [7:0] fifo_cs;
        logic act;
        logic irq;
    } usbsie_core_s;

    localparam usbsie_core_s CORE_RST = '{
        line_flags: usbsie_pkg::RST_LINE_FLAGS,
        dir_in: usbsie_pkg::RST_DIRECTION[3:1],
        data0: usbsie_pkg::RST_DIRECTION[usbsie_pkg::DIR_DATA0],
        halt: usbsie_pkg::RST_HALT[3:0],
        access: usbsie_pkg::RST_ACCESS,
        adr_set: 1'b0,
        fifo_zero_error: 1'b0,
        nak_filt: 1'b0,
        enable: usbsie_pkg::RST_ENABLE[3:0],
        addr_reg: usbsie_pkg::RST_DEV_ADDR,
        dev_addr: usbsie_pkg::RST_DEV_ADDR[6:0],
        req: usbsie_pkg::RST_REQUEST,
        fifo_cs: usbsie_pkg::RST_FIFO_CS,
        act: 1'b0,
        irq: 1'b0
    };

    usbsie_reg_if rif ();

    usbsie_core_s cur;
    usbsie_core_s next_cur;

    // bus slave front end
    usbsie_ahb #(
        .ADDR_W(HADDR_W)
    ) u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rif(rif)
    );

    // decoded write strobes
    logic wr_line;
    logic wr_dir;
    logic wr_halt;
    logic wr_status;
    logic wr_fifo;
    logic wr_enable;
    logic wr_addr;
    logic wr_req;
    logic [7:0] wd;

    // shared write decode: one register hit per bus write
    function automatic logic wr_hit(
        input logic en,
        input logic [7:0] idx,
        input logic [7:0] target
    );
        return en && (idx == target);
    endfunction : wr_hit

    assign wd = rif.wr_data;
    assign wr_line = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_LINE_FLAGS);
    assign wr_dir = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_DIRECTION);
    assign wr_halt = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_HALT);
    assign wr_status = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_STATUS);
    assign wr_fifo = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_FIFO_CS);
    assign wr_enable = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_ENABLE);
    assign wr_addr = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_DEV_ADDR);
    assign wr_req = wr_hit(rif.wr_en, rif.wr_idx, usbsie_pkg::IDX_REQUEST);

    // host access qualification: endpoint 0 ignores the enable bit
    logic [3:0] ep_onehot;
    logic ep_open;
    logic access_ok;
    logic req_ok;
    logic [4:0] line_ev;

    assign ep_onehot = 4'h1 << host_ep;
    assign ep_open = (host_ep == 2'h0) || cur.enable[host_ep];
    assign access_ok = host_access && ep_open;
    // endpoint 0 with the filter on skips nak-answered tokens
    assign req_ok = access_ok && !((host_ep == 2'h0) && cur.nak_filt && host_nak);

    // request bits to set this cycle
    logic [3:0] req_set;
    assign req_set = req_ok ? ep_onehot : 4'h0;

    // bus-line events in the register's bit order
    assign line_ev[usbsie_pkg::LF_EOP] = ev_eop;
    assign line_ev[usbsie_pkg::LF_J] = ev_j_state;
    assign line_ev[usbsie_pkg::LF_K] = ev_k_state;
    assign line_ev[usbsie_pkg::LF_SE0] = ev_se0_noise;
    assign line_ev[usbsie_pkg::LF_SE1] = ev_se1_noise;

    // sticky flag update: a write of zero clears, a hardware set in the same
    // cycle wins so that no event is lost
    function automatic logic [7:0] sticky(
        input logic [7:0] old,
        input logic [7:0] set,
        input logic clr_en,
        input logic [7:0] wdat
    );
        logic [7:0] kept;
        kept = clr_en ? (old & wdat) : old;
        return kept | set;
    endfunction : sticky

    // next-state logic of all control and status
    always_comb begin
        logic [7:0] tmp;
        tmp = 8'h00;
        next_cur = cur;

        // bus-line events
        tmp = sticky({3'h0, cur.line_flags}, {3'h0, line_ev}, wr_line, wd);
        next_cur.line_flags = tmp[4:0];

        // direction and toggle control
        if (wr_dir) begin
            next_cur.dir_in = wd[3:1];
            next_cur.data0 = wd[usbsie_pkg::DIR_DATA0];
        end

        // halt bits are firmware owned and reflected straight out
        if (wr_halt) begin
            next_cur.halt = wd[3:0];
        end

        // endpoint enables
        if (wr_enable) begin
            next_cur.enable = wd[3:0];
        end

        // access flags show the endpoint of the latest accepted access;
        // no bus write reaches them
        // a probe of a disabled endpoint leaves no trace here
        if (access_ok) begin
            next_cur.access = ep_onehot;
        end
        // one-cycle pulse; firmware polls the access flags after it
        next_cur.act = access_ok;

        // request flags, firmware clears by writing zero
        tmp = sticky({4'h0, cur.req}, {4'h0, req_set}, wr_req, wd);
        next_cur.req = tmp[3:0];
        next_cur.irq = |next_cur.req;

        // status register: firmware fields and the fifo0 error flag
        if (wr_status) begin
            next_cur.adr_set = wd[usbsie_pkg::ST_ADR_SET];
            next_cur.nak_filt = wd[usbsie_pkg::ST_NAK_FILT];
        end
        // sticky error flag; an error in the cycle of a clear is kept
        if (wr_status && !wd[usbsie_pkg::ST_FIFO_ZERO_ERROR]) begin
            next_cur.fifo_zero_error = 1'b0;
        end
        if (fifo0_err_ev) begin
            next_cur.fifo_zero_error = 1'b1;
        end

        // address register; immediate apply unless deferred
        if (wr_addr) begin
            next_cur.addr_reg = wd;
            if (!cur.adr_set) begin
                next_cur.dev_addr = wd[6:0];
            end
        end

        // deferred load after the host has read IN data successfully; a status
        // write in the same cycle yields to the engine's own clear
        if (cur.adr_set && in_read_ok) begin
            next_cur.dev_addr = cur.addr_reg[6:0];
            next_cur.adr_set = 1'b0;
        end

        // fifo command/status, layout kept opaque here
        if (wr_fifo) begin
            next_cur.fifo_cs = wd;
        end
        if (usb_bus_reset) begin
            next_cur.fifo_cs = usbsie_pkg::RST_FIFO_CS;
        end
    end

    // single state register; the async branch loads constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= CORE_RST;
        end else begin
            cur <= next_cur;
        end
    end

    // read mux; unmapped indices read zero
    // reads have no side effect, so polling never loses a flag
    always_comb begin
        rif.rd_data = 8'h00;
        unique case (rif.rd_idx)
            usbsie_pkg::IDX_LINE_FLAGS: begin
                rif.rd_data = {3'h0, cur.line_flags};
            end
            usbsie_pkg::IDX_DIRECTION: begin
                rif.rd_data = {4'h0, cur.dir_in, cur.data0};
            end
            usbsie_pkg::IDX_HALT: begin
                rif.rd_data = {4'h0, cur.halt};
            end
            usbsie_pkg::IDX_ACCESS: begin
                rif.rd_data = {4'h0, cur.access};
            end
            usbsie_pkg::IDX_STATUS: begin
                rif.rd_data = {cur.nak_filt, 5'h00, cur.fifo_zero_error, cur.adr_set};
            end
            usbsie_pkg::IDX_FIFO_CS: begin
                rif.rd_data = cur.fifo_cs;
            end
            usbsie_pkg::IDX_ENABLE: begin
                rif.rd_data = {4'h0, cur.enable};
            end
            usbsie_pkg::IDX_DEV_ADDR: begin
                // the stored byte reads back while a deferred load waits
                rif.rd_data = cur.addr_reg;
            end
            usbsie_pkg::IDX_REQUEST: begin
                rif.rd_data = {4'h0, cur.req};
            end
            default: begin
                rif.rd_data = 8'h00;
            end
        endcase
    end

    // outputs, each straight from the state register
    assign activity_strobe = cur.act;
    assign usb_irq = cur.irq;
    assign dev_addr = cur.dev_addr;
    assign remote_wakeup = cur.addr_reg[usbsie_pkg::DA_WAKEUP];
    assign ep_dir_in = cur.dir_in;
    assign ep_halt = cur.halt;
    assign ep_enabled = cur.enable[3:1];
    // toggles held at DATA0 for as long as firmware keeps the bit low
    assign toggle_clear = ~cur.data0;
    assign fifo_cmd_status = cur.fifo_cs;
endmodule : usbsie_ctrl

// >>> hw/usbsie_pkg.sv
// usbsie_pkg: register map, field positions and reset values of the engine control block
package usbsie_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_LINE_FLAGS = 8'h40;
    localparam logic [7:0] IDX_DIRECTION = 8'h41;
    localparam logic [7:0] IDX_HALT = 8'h43;
    localparam logic [7:0] IDX_ACCESS = 8'h44;
    localparam logic [7:0] IDX_STATUS = 8'h45;
    localparam logic [7:0] IDX_FIFO_CS = 8'h46;
    localparam logic [7:0] IDX_ENABLE = 8'h47;
    localparam logic [7:0] IDX_DEV_ADDR = 8'h4C;
    localparam logic [7:0] IDX_REQUEST = 8'h4D;

    // reset values
    localparam logic [7:0] RST_DIRECTION = 8'h0E;
    localparam logic [7:0] RST_HALT = 8'h0E;
    localparam logic [3:0] RST_ACCESS = 4'h0;
    localparam logic [7:0] RST_ENABLE = 8'h0F;
    localparam logic [4:0] RST_LINE_FLAGS = 5'h00;
    localparam logic [7:0] RST_FIFO_CS = 8'h00;
    localparam logic [7:0] RST_DEV_ADDR = 8'h00;
    localparam logic [3:0] RST_REQUEST = 4'h0;

    // bus-line event flag positions
    localparam int LF_EOP = 0;
    localparam int LF_J = 1;
    localparam int LF_K = 2;
    localparam int LF_SE0 = 3;
    localparam int LF_SE1 = 4;

    // engine status/control field positions
    localparam int ST_ADR_SET = 0;
    localparam int ST_FIFO_ZERO_ERROR = 1;
    localparam int ST_NAK_FILT = 7;

    // direction register: bit 0 is the toggle control
    localparam int DIR_DATA0 = 0;

    // device address register: low seven bits address, top bit remote wakeup
    localparam int DA_WAKEUP = 7;

    // bus index field within haddr
    localparam int HADDR_IDX_LO = 2;
    localparam int HADDR_IDX_HI = 9;
endpackage : usbsie_pkg

// >>> hw/usbsie_reg_if.sv
// usbsie_reg_if: register access strobes between the bus slave and the engine core
`timescale 1ns/1ns
interface usbsie_reg_if;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;

    modport bus (
        output rd_idx,
        input rd_data,
        output wr_en,
        output wr_idx,
        output wr_data
    );

    modport core (
        input rd_idx,
        output rd_data,
        input wr_en,
        input wr_idx,
        input wr_data
    );
endinterface : usbsie_reg_if

// >>> hw/usbsie_ahb.sv
// usbsie_ahb: zero-wait AHB-Lite slave front end for the engine registers
`timescale 1ns/1ns
module usbsie_ahb #(
    parameter int ADDR_W = 32
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // register side
    usbsie_reg_if.bus rif
);
    initial begin
        if (ADDR_W < 10) begin
            $error("usbsie_ahb: ADDR_W must be at least 10");
        end
    end

    typedef struct packed {
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic rdy;
    } usbsie_ahb_s;

    usbsie_ahb_s cur;
    usbsie_ahb_s next_cur;
    logic take;

    // a transfer is accepted on nonseq/seq with the bus ready; size is not checked,
    // only whole words are expected
    assign take = hsel && htrans[1] && hready;
    assign rif.rd_idx = haddr[usbsie_pkg::HADDR_IDX_HI:usbsie_pkg::HADDR_IDX_LO];
    assign rif.wr_en = cur.wr_pend;
    assign rif.wr_idx = cur.wr_idx;
    assign rif.wr_data = hwdata[7:0];

    // read data is captured at the address phase so no wait state is needed
    always_comb begin
        next_cur = cur;
        next_cur.rdy = 1'b1;
        next_cur.wr_pend = take && hwrite;
        if (take) begin
            next_cur.wr_idx = haddr[usbsie_pkg::HADDR_IDX_HI:usbsie_pkg::HADDR_IDX_LO];
        end
        if (take && !hwrite) begin
            next_cur.rdata = {24'h000000, rif.rd_data};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur <= '{wr_pend: 1'b0, wr_idx: 8'h00, rdata: 32'h00000000, rdy: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    assign hrdata = cur.rdata;
    assign hreadyout = cur.rdy;
    assign hresp = 1'b0; // always okay
endmodule : usbsie_ahb

// >>> verification/usbsie_host_model.sv
// usbsie_host_model: low-speed host side, turns bench commands into engine event pulses
`timescale 1ns/1ns
module usbsie_host_model (
    // command from the bench
    input wire logic hclk,
    input wire logic go,
    input wire logic [3:0] op,
    input wire logic [1:0] ep,
    input wire logic nak,
    // engine events
    output logic [8:0] pulse,
    output logic [1:0] host_ep,
    output logic host_nak
);
    // one pulse per command; endpoint lines scramble outside an access so stale values never help
    always @(posedge hclk) begin
        pulse <= go ? 9'h001 << op : 9'h000;
        host_ep <= go ? ep : ~host_ep;
        host_nak <= go ? nak : ~host_nak;
    end
    initial begin
        pulse = 9'h000;
        host_ep = 2'h0;
        host_nak = 1'b0;
    end
endmodule : usbsie_host_model

// >>> verification/usbsie_ctrl_chk.sv
// usbsie_ctrl_chk: port-level assertions for the engine control block
`timescale 1ns/1ns
module usbsie_ctrl_chk #(
    parameter int HADDR_W = 32,
    parameter int EP_NUM = 4
) (
    // clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [HADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    // engine side
    input wire logic host_access,
    input wire logic [1:0] host_ep,
    input wire logic in_read_ok,
    input wire logic usb_bus_reset,
    input wire logic activity_strobe,
    input wire logic usb_irq,
    input wire logic [6:0] dev_addr,
    input wire logic [2:0] ep_dir_in,
    input wire logic [2:0] ep_enabled,
    input wire logic toggle_clear,
    input wire logic [7:0] fifo_cmd_status
);
    logic a_wr, a_rd, ok_ep;
    logic [7:0] a_idx;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // an access counts only for endpoint 0 or an enabled endpoint
    assign ok_ep = host_access & (host_ep == 2'h0 || ep_enabled[host_ep - 2'h1]);
    // data phase tracker: the bus alone does not say which register a data phase is for
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_wr <= 1'b0;
            a_rd <= 1'b0;
            a_idx <= 8'h00;
        end else begin
            a_wr <= hsel & htrans[1] & hready & hwrite;
            a_rd <= hsel & htrans[1] & hready & ~hwrite;
            a_idx <= haddr[9:2];
        end
    end
    ready_hold_a: assert property (hreadyout)
        else $error("wait state seen");
    strobe_set_a: assert property (ok_ep |=> activity_strobe)
        else $error("no strobe");
    no_strobe_a: assert property (!ok_ep |=> !activity_strobe)
        else $error("stray strobe");
    irq_raise_a: assert property (ok_ep && host_ep != 2'h0 |=> usb_irq)
        else $error("no irq");
    dir_write_a: assert property (a_wr && a_idx == usbsie_pkg::IDX_DIRECTION |=>
        ep_dir_in == $past(hwdata[3:1]) && toggle_clear == !$past(hwdata[0])) else $error("dir");
    enable_write_a: assert property (a_wr && a_idx == usbsie_pkg::IDX_ENABLE |=>
        ep_enabled == $past(hwdata[3:1])) else $error("enable");
    fifo_rst_a: assert property (usb_bus_reset |=> fifo_cmd_status == 8'h00)
        else $error("fifo not cleared");
    addr_hold_a: assert property (!(a_wr && a_idx == usbsie_pkg::IDX_DEV_ADDR) &&
        !in_read_ok |=> $stable(dev_addr)) else $error("address moved");
    unused_zero_a: assert property (a_rd && a_idx == usbsie_pkg::IDX_LINE_FLAGS |->
        hrdata[31:5] == 27'h0) else $error("unused bits set");
endmodule : usbsie_ctrl_chk
bind usbsie_ctrl usbsie_ctrl_chk #(.HADDR_W(HADDR_W), .EP_NUM(EP_NUM)) chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .host_access(host_access), .host_ep(host_ep), .in_read_ok(in_read_ok),
    .usb_bus_reset(usb_bus_reset), .activity_strobe(activity_strobe), .usb_irq(usb_irq),
    .dev_addr(dev_addr), .ep_dir_in(ep_dir_in), .ep_enabled(ep_enabled),
    .toggle_clear(toggle_clear), .fifo_cmd_status(fifo_cmd_status));

// >>> verification/tb_usbsie_ctrl.sv
// tb_usbsie_ctrl: self-checking bench for the engine control block
`timescale 1ns/1ns
module tb_usbsie_ctrl;
    localparam logic [7:0] LF = usbsie_pkg::IDX_LINE_FLAGS, DR = usbsie_pkg::IDX_DIRECTION,
        HT = usbsie_pkg::IDX_HALT, AC = usbsie_pkg::IDX_ACCESS, ST = usbsie_pkg::IDX_STATUS,
        FC = usbsie_pkg::IDX_FIFO_CS, EN = usbsie_pkg::IDX_ENABLE,
        DA = usbsie_pkg::IDX_DEV_ADDR, RQ = usbsie_pkg::IDX_REQUEST;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, hnak = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, hep = 2'h0, host_ep;
    logic [3:0] op = 4'h0, ep_halt;
    logic [8:0] pulse;
    logic hreadyout, hresp, host_nak, activity_strobe, usb_irq, remote_wakeup, toggle_clear;
    logic stb, irq;
    logic [6:0] dev_addr;
    logic [2:0] ep_dir_in, ep_enabled;
    logic [7:0] fifo_cmd_status, v;
    logic [7:0] m [0:255];
    logic [7:0] idxs [11] = '{LF, DR, HT, AC, ST, FC, EN, DA, RQ, 8'h42, 8'h50};
    int bad_count = 0, tests_run = 0, seed = 32'h72d5, n;
    usbsie_ctrl dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ev_eop(pulse[0]), .ev_j_state(pulse[1]),
        .ev_k_state(pulse[2]), .ev_se0_noise(pulse[3]), .ev_se1_noise(pulse[4]),
        .host_access(pulse[5]), .host_ep(host_ep), .host_nak(host_nak), .in_read_ok(pulse[6]),
        .fifo0_err_ev(pulse[7]), .usb_bus_reset(pulse[8]), .activity_strobe(activity_strobe),
        .usb_irq(usb_irq), .dev_addr(dev_addr), .remote_wakeup(remote_wakeup),
        .ep_dir_in(ep_dir_in), .ep_halt(ep_halt), .ep_enabled(ep_enabled),
        .toggle_clear(toggle_clear), .fifo_cmd_status(fifo_cmd_status));
    usbsie_host_model host_m (.hclk(hclk), .go(go), .op(op), .ep(hep), .nak(hnak),
        .pulse(pulse), .host_ep(host_ep), .host_nak(host_nak));
    // free-running system clock
    always #5 hclk = ~hclk;
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // bounded wait for hready; a hung slave ends the run
    task automatic wait_rdy;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            finish_test();
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] i, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {22'h0, i, 2'h0};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rd = hrdata;
    endtask : bus
    // reserved upper nibble of the direction, halt and enable registers is left unchecked
    task automatic rdchk(input logic [7:0] i);
        bus(1'b0, i, 8'h00);
        cmp(rd & ((i == DR || i == HT || i == EN) ? 32'hFFFFFF0F : 32'hFFFFFFFF), {24'h0, m[i]});
    endtask : rdchk
    task automatic host(input logic [3:0] o, input logic [1:0] e, input logic k);
        @(posedge hclk);
        go <= 1'b1;
        op <= o;
        hep <= e;
        hnak <= k;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        #1;
        stb = activity_strobe;
        irq = usb_irq;
    endtask : host
    // main sequence; m holds the expected register contents
    initial begin
        for (int i = 0; i < 256; i++) m[i] = 8'h00;
        m[DR] = usbsie_pkg::RST_DIRECTION;
        m[HT] = usbsie_pkg::RST_HALT;
        m[EN] = usbsie_pkg::RST_ENABLE;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (idxs[i]) rdchk(idxs[i]);
        repeat (2) begin
            v = 8'($random(seed));
            bus(1'b1, DR, v);
            bus(1'b1, HT, ~v);
            bus(1'b1, EN, v ^ 8'h5A);
            bus(1'b1, FC, v + 8'h11);
            m[DR] = v & 8'h0F;
            m[HT] = ~v & 8'h0F;
            m[EN] = (v ^ 8'h5A) & 8'h0F;
            m[FC] = v + 8'h11;
            for (int i = 1; i < 7; i++) rdchk(idxs[i]);
            cmp({ep_dir_in, toggle_clear, ep_halt, ep_enabled},
                {m[DR][3:1], ~m[DR][0], m[HT][3:0], m[EN][3:1]});
            cmp(fifo_cmd_status, m[FC]);
        end
        bus(1'b1, AC, 8'hFF);
        rdchk(AC);
        for (int e = 0; e < 5; e++) begin
            host(4'(e), 2'h0, 1'b0);
            m[LF] = m[LF] | (8'h01 << e);
            rdchk(LF);
        end
        bus(1'b1, LF, 8'hEA);
        m[LF] = m[LF] & 8'hEA;
        rdchk(LF);
        bus(1'b1, EN, 8'h0F);
        for (int e = 0; e < 4; e++) begin
            host(4'h5, 2'(e), 1'b0);
            cmp({stb, irq}, 2'b11);
            m[AC] = 8'h01 << e;
            m[RQ] = m[RQ] | m[AC];
            rdchk(AC);
            rdchk(RQ);
        end
        bus(1'b1, RQ, 8'h00);
        m[RQ] = 8'h00;
        rdchk(RQ);
        cmp(usb_irq, 1'b0);
        bus(1'b1, EN, 8'h0B);
        host(4'h5, 2'h2, 1'b0);
        cmp({stb, irq}, 2'b00);
        rdchk(AC);
        rdchk(RQ);
        // endpoint 0 filter: on with NAK, on with data, off with NAK
        bus(1'b1, ST, 8'h80);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                bus(1'b1, ST, 8'h00);
            end
            bus(1'b1, RQ, 8'h00);
            host(4'h5, 2'h0, k != 1);
            m[AC] = 8'h01;
            m[RQ] = (k == 0) ? 8'h00 : 8'h01;
            cmp({stb, irq}, {1'b1, k != 0});
            rdchk(RQ);
        end
        host(4'h7, 2'h0, 1'b0);
        m[ST] = 8'h02;
        rdchk(ST);
        bus(1'b1, ST, 8'h00);
        m[ST] = 8'h00;
        rdchk(ST);
        bus(1'b1, DA, 8'h85);
        m[DA] = 8'h85;
        rdchk(DA);
        cmp({remote_wakeup, dev_addr}, 8'h85);
        bus(1'b1, ST, 8'h01);
        bus(1'b1, DA, 8'h23);
        m[ST] = 8'h01;
        rdchk(ST);
        cmp(dev_addr, 7'h05);
        host(4'h6, 2'h0, 1'b0);
        cmp(dev_addr, 7'h23);
        m[ST] = 8'h00;
        rdchk(ST);
        host(4'h8, 2'h0, 1'b0);
        m[FC] = 8'h00;
        cmp(fifo_cmd_status, 8'h00);
        rdchk(FC);
        // toggle reset: bit 0 held low well past ten cycles
        bus(1'b1, DR, 8'h08);
        repeat (12) @(posedge hclk);
        cmp(toggle_clear, 1'b1);
        bus(1'b1, DR, 8'h09);
        m[DR] = 8'h09;
        rdchk(DR);
        cmp({hresp, toggle_clear, ep_dir_in}, 5'h04);
        finish_test();
    end
endmodule : tb_usbsie_ctrl
